// >>> dv/trs_assertions.sv
`timescale 1ns/10ps
module trs_assertions
  import trs_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and outputs
  input wire trs_pins_t   pins,
  input wire logic [15:0] ro_word,
  input wire logic        ro_strobe,
  input wire logic        request_queue_warning,
  input wire logic        buffer_nearly_full,
  input wire logic [15:0] daq_data,
  input wire logic        daq_valid,
  input wire logic        daq_last
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since last request start, saturating
  logic [7:0] gap;
  logic       seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap  <= 8'hff;
      seen <= 1'b0;
    end else if ($rose(ro_strobe)) begin
      gap  <= 8'h00;
      seen <= 1'b1;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("apb setup not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response malformed");
  strobe_three_a: assert property ($rose(ro_strobe) |-> ro_strobe [*3] ##1 !ro_strobe)
    else $error("request not three words");
  req_mark_a: assert property ($rose(ro_strobe) |-> ro_word[15:12] == ID_MARK)
    else $error("request id word mark wrong");
  bcn_word_a: assert property ($rose(ro_strobe) |-> ##2 ro_word[15:12] == 4'h0 && ro_word[BCW-1:0] <= BC_LIMIT)
    else $error("request bunch word out of range");
  req_gap_a: assert property ($rose(ro_strobe) && seen |-> gap >= 8'h15)
    else $error("requests closer than 22 cycles");
  // three quiet ready cycles cover any sync depth up to three
  daq_hold_a: assert property (daq_valid && !$past(pins.daq_ready) && !$past(pins.daq_ready, 2)
    && !$past(pins.daq_ready, 3) |=> daq_valid && $stable(daq_data))
    else $error("daq word dropped while not ready");
  daq_trailer_a: assert property (daq_valid && daq_last |-> daq_data[15:12] == FMT_TRL)
    else $error("last word not a trailer");
  cover property ($rose(request_queue_warning));
  cover property ($rose(buffer_nearly_full));
  cover property (daq_valid && daq_last);
endmodule : trs_assertions

// >>> dv/trs_daq_model.sv
`timescale 1ns/10ps
module trs_daq_model
  import trs_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // event stream
  input  wire logic [15:0] daq_data,
  input  wire logic        daq_valid,
  input  wire logic        daq_last,
  input  wire logic        stall,
  output logic             daq_ready,
  // tallies
  output logic [7:0]       events,
  output logic [7:0]       last_len,
  output logic [15:0]      first_word
);
  logic [1:0] rdy_d;
  logic [1:0] phase;
  logic [7:0] len;
  // ready drops one cycle in four so the stream keeps stalling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_d      <= 2'b00;
      phase      <= 2'b00;
      len        <= 8'h00;
      daq_ready  <= 1'b0;
      events     <= 8'h00;
      last_len   <= 8'h00;
      first_word <= 16'h0000;
    end else begin
      phase     <= phase + 2'b01;
      daq_ready <= !stall && phase != 2'b11;
      rdy_d     <= {rdy_d[0], daq_ready};
      // design sees ready two edges late
      if (daq_valid && rdy_d[1]) begin
        len <= daq_last ? 8'h00 : len + 8'h01;
        if (len == 8'h00) begin
          first_word <= daq_data;
        end
        if (daq_last) begin
          events   <= events + 8'h01;
          last_len <= len + 8'h01;
        end
      end
    end
  end
endmodule : trs_daq_model

// >>> dv/trs_readout_seq_test.sv
`timescale 1ns/10ps
module trs_readout_seq_test
  import trs_pkg::*;
;
  localparam logic [11:0] RA [5] = '{REG_CTRL, REG_MON_PERIOD, REG_CH_EN, REG_QWARN, REG_BWARN};
  localparam logic [31:0] RV [5] = '{32'(CTRL_RST), 32'(PERIOD_RST), 32'(CHEN_RST), 32'(QWARN_RST), 32'(BWARN_RST)};
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  trs_pins_t   pin_drv;
  trs_pins_t   pins;
  logic [15:0] ro_word;
  logic        ro_strobe;
  logic        request_queue_warning;
  logic        buffer_nearly_full;
  logic [15:0] daq_data;
  logic        daq_valid;
  logic        daq_last;
  logic        daq_ready;
  logic        stall;
  logic [7:0]  events;
  logic [7:0]  last_len;
  logic [15:0] first_word;
  logic        qw_seen = 1'b0;
  logic [15:0] last_bunch;
  logic [31:0] rd;
  logic        er;
  int          miscompares;
  int          total_checks;
  int          wi = 0;
  logic [15:0] rq [3][$];
  trs_readout_seq trs_readout_seq_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .pins, .ro_word, .ro_strobe, .request_queue_warning, .buffer_nearly_full,
    .daq_data, .daq_valid, .daq_last);
  trs_daq_model trs_daq_model_i (.pclk, .presetn, .daq_data, .daq_valid, .daq_last, .stall, .daq_ready,
    .events, .last_len, .first_word);
  always_comb begin
    pins = pin_drv;
    pins.daq_ready = daq_ready;
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // bus monitor: id, event and bunch words of each request
  always @(posedge pclk) begin
    if (ro_strobe) begin
      rq[wi].push_back(ro_word);
      wi = (wi + 1) % 3;
    end
    if (request_queue_warning) begin
      qw_seen <= 1'b1;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic accepts(input int n, input int base);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      pin_drv.l1a     <= 1'b1;
      pin_drv.ttc_evn <= EVW'(base + k);
      pin_drv.ttc_bcn <= BCW'(base + k);
    end
    @(posedge pclk);
    pin_drv.l1a <= 1'b0;
  endtask : accepts
  task automatic get_reqs(input int nl, input int base, input int nm, input logic [1:0] kind);
    for (int t = 0; t < 3000 && rq[2].size() < nl + nm; t++) @(posedge pclk);
    repeat (30) @(posedge pclk);
    chk("request count", 32'(nl + nm), 32'(rq[2].size()));
    for (int k = 0; k < rq[2].size(); k++) begin
      chk("request mark", 32'(ID_MARK), 32'(rq[0][k][15:12]));
      chk("request kind", k < nl ? 32'h0 : 32'(kind), 32'(rq[0][k][1:0]));
      if (k < nl) begin
        chk("request event", 32'(base + k) & 32'h0000_ffff, 32'(rq[1][k]));
        chk("request bunch", 32'(base + k), 32'(rq[2][k]));
      end
    end
    if (rq[2].size() > 0) last_bunch = rq[2][rq[2].size() - 1];
    foreach (rq[i]) rq[i].delete();
  endtask : get_reqs
  task automatic wait_ev(input logic [7:0] n);
    for (int t = 0; t < 2000 && events < n; t++) @(posedge pclk);
    repeat (40) @(posedge pclk);
  endtask : wait_ev
  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    complete_run();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    paddr = 12'h000;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pin_drv = '0;
    // constant crossing data makes ring contents predictable
    for (int c = 0; c < NCH; c++) pin_drv.ch_data[c] = 16'h0a50 + 16'(c);
    stall = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    foreach (RA[i]) begin
      apb(RA[i], 1'b0, 32'h0);
      chk("reset value", RV[i], rd);
    end
    apb(12'h0fc, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, 32'(er));
    apb(REG_QWARN, 1'b1, 32'h3);
    accepts(5, 'h10);
    apb(REG_MON_CMD, 1'b1, 32'h1);
    get_reqs(5, 'h10, 1, 2'b01);
    chk("queue warning", 32'h1, 32'(qw_seen));
    wait_ev(8'd5);
    chk("event count", 32'h5, 32'(events));
    chk("event length", 32'(EVT_MAX), 32'(last_len));
    chk("event header", 32'(FMT_EVH), 32'(first_word[15:12]));
    // channel tags stay zero and short numbers start unaligned, so all flags set
    apb(REG_ALIGN, 1'b0, 32'h0);
    chk("align flags", 32'h0000_00ff, rd);
    apb(REG_ALIGN, 1'b1, 32'h0000_00ff);
    apb(REG_ALIGN, 1'b0, 32'h0);
    chk("align cleared", 32'h0, rd);
    apb(REG_MON_ADDR, 1'b1, 32'h0);
    apb(REG_MON_DATA, 1'b0, 32'h0);
    chk("monitor header", 32'({FMT_CH, 6'h00}), 32'(rd[15:6]));
    apb(REG_MON_DATA, 1'b0, 32'h0);
    chk("monitor data", 32'h0a50, rd);
    apb(REG_MON_CMD, 1'b1, 32'h3);
    get_reqs(0, 0, 1, 2'b11);
    // orbit reset leads by one crossing, so the pin request sees bunch zero
    pin_drv.bcr <= 1'b1;
    @(posedge pclk);
    pin_drv.mon_ext <= 1'b1;
    repeat (4) @(posedge pclk);
    pin_drv.mon_ext <= 1'b0;
    pin_drv.bcr     <= 1'b0;
    get_reqs(0, 0, 1, 2'b01);
    chk("orbit bunch", 32'h0, 32'(last_bunch));
    apb(REG_MON_PERIOD, 1'b1, 32'h00c8);
    apb(REG_CTRL, 1'b1, 32'h5);
    get_reqs(0, 0, 2, 2'b01);
    apb(REG_CTRL, 1'b1, 32'h4);
    chk("monitor kept off daq", 32'h5, 32'(events));
    apb(REG_CH_EN, 1'b1, 32'h3);
    accepts(1, 'h20);
    get_reqs(1, 'h20, 0, 2'b00);
    wait_ev(8'd6);
    chk("excluded length", 32'(2 + 2 * REC_WORDS), 32'(last_len));
    apb(REG_CH_EN, 1'b1, 32'hf);
    apb(REG_CTRL, 1'b1, 32'h0);
    apb(REG_BWARN, 1'b1, 32'h0);
    stall <= 1'b1;
    accepts(1, 'h30);
    get_reqs(1, 'h30, 0, 2'b00);
    chk("held events", 32'h6, 32'(events));
    chk("nearly full", 32'h1, 32'(buffer_nearly_full));
    pin_drv.daq_pull <= 1'b1;
    repeat (4) @(posedge pclk);
    pin_drv.daq_pull <= 1'b0;
    repeat (10) @(posedge pclk);
    stall <= 1'b0;
    wait_ev(8'd7);
    chk("pulled events", 32'h7, 32'(events));
    chk("drained warning", 32'h0, 32'(buffer_nearly_full));
    complete_run();
  end
endmodule : trs_readout_seq_test
bind trs_readout_seq trs_assertions trs_assertions_i (.pclk, .presetn, .psel, .penable, .prdata, .pready,
  .pslverr, .pins, .ro_word, .ro_strobe, .request_queue_warning, .buffer_nearly_full, .daq_data, .daq_valid,
  .daq_last);

// >>> rtl/trs_pkg.sv
package trs_pkg;
  localparam int NCH       = 4;
  localparam int CW        = 2;
  localparam int HIST      = 3;
  localparam int BCW       = 12;
  localparam int EVW       = 24;
  localparam int QLOG      = 6;
  localparam int ELOG      = 10;
  localparam int MON_SLOTS = 4;
  localparam int REC_WORDS = 1 + HIST;
  localparam int MALOG     = 6;

  // register offsets
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_MON_CMD    = 12'h004;
  localparam logic [11:0] REG_MON_PERIOD = 12'h008;
  localparam logic [11:0] REG_CH_EN      = 12'h00c;
  localparam logic [11:0] REG_QWARN      = 12'h010;
  localparam logic [11:0] REG_BWARN      = 12'h014;
  localparam logic [11:0] REG_STATUS     = 12'h018;
  localparam logic [11:0] REG_ALIGN      = 12'h01c;
  localparam logic [11:0] REG_MON_ADDR   = 12'h020;
  localparam logic [11:0] REG_MON_DATA   = 12'h024;

  // control field positions and reset values
  localparam int CTRL_PER     = 0;
  localparam int CTRL_STAT    = 1;
  localparam int CTRL_AUTO    = 2;
  localparam int CTRL_RED_EVN = 3;
  localparam int CTRL_RED_BCN = 4;
  localparam logic [4:0]      CTRL_RST   = 5'h04;
  localparam logic [15:0]     PERIOD_RST = 16'h1000;
  localparam logic [NCH-1:0]  CHEN_RST   = 4'hf;
  localparam logic [QLOG:0]   QWARN_RST  = 7'h30;
  localparam logic [ELOG:0]   BWARN_RST  = 11'h300;

  // bunch counter wraps after 3564 crossings
  localparam logic [BCW-1:0]  BC_LIMIT   = 12'hdeb;

  // identifier word bits and format words
  localparam int ID_MON  = 0;
  localparam int ID_STAT = 1;
  localparam int ID_UPD  = 2;
  localparam logic [3:0] ID_MARK = 4'ha;
  localparam logic [3:0] FMT_EVH = 4'h1;
  localparam logic [3:0] FMT_CH  = 4'h5;
  localparam logic [3:0] FMT_TRL = 4'hf;

  localparam logic [ELOG:0] EVB_SIZE = 11'h400;
  localparam logic [ELOG:0] EVT_MAX  = 11'(2 + NCH * REC_WORDS);

  typedef struct packed {
    logic [15:0]    id;
    logic [EVW-1:0] evn;
    logic [BCW-1:0] bcn;
  } trs_req_t;

  typedef struct packed {
    logic                     l1a;
    logic                     bcr;
    logic                     mon_ext;
    logic                     daq_pull;
    logic                     daq_ready;
    logic [EVW-1:0]           ttc_evn;
    logic [BCW-1:0]           ttc_bcn;
    logic [NCH-1:0][15:0]     ch_data;
    logic [NCH-1:0][BCW-1:0]  ch_bcn;
  } trs_pins_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_BUS  = 6'h02,
    S_HDR  = 6'h04,
    S_CH   = 6'h08,
    S_DATA = 6'h10,
    S_TRL  = 6'h20
  } trs_seq_t;
endpackage : trs_pkg

// >>> rtl/trs_queue.sv
`timescale 1ns/10ps
module trs_queue
  import trs_pkg::*;
#(
  parameter int W    = 8,
  parameter int ALOG = 6
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // fill side
  input  wire logic          in_valid,
  input  wire logic [W-1:0]  in_data,
  output logic               in_ready,
  // drain side
  output logic               out_valid,
  output logic [W-1:0]       out_data,
  input  wire logic          out_ready,
  output logic [ALOG:0]      count
);
  typedef struct packed {
    logic [ALOG-1:0] wp;
    logic [ALOG-1:0] rp;
    logic [ALOG:0]   cnt;
  } trs_qst_t;

  trs_qst_t       r;
  trs_qst_t       n;
  logic [W-1:0]   mem [2**ALOG];
  logic           push;
  logic           pop;

  assign in_ready  = r.cnt != (ALOG+1)'(2**ALOG);
  assign out_valid = r.cnt != '0;
  assign out_data  = mem[r.rp];
  assign count     = r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;

  always_comb begin
    n = r;
    if (push) n.wp = r.wp + 1'b1;
    if (pop) n.rp = r.rp + 1'b1;
    n.cnt = r.cnt + (ALOG+1)'(push) - (ALOG+1)'(pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r <= '0;
    else r <= n;
  end

  always_ff @(posedge pclk) begin
    if (push) mem[r.wp] <= in_data;
  end
endmodule : trs_queue

// >>> rtl/trs_readout_seq.sv
`timescale 1ns/10ps
// Contract
// - each accept pushes identifier, event number and bunch count into request queue (an accept arriving while the 64-entry queue is full is dropped)
// - reduced receiver mode takes event or bunch number from local counters
// - keep issuing requests from accept queue until it is empty
// - monitoring queue served only when no accept request waits
// - issue requests only while the collector accepts new events
// - accepts taken on every crossing, no minimum spacing
// - queue warning output raised before accept queue is full
// - monitoring requests from pin or register, single or periodic, ring or statistics
// - requests broadcast over a 16-bit readout bus
// - request bunch number addresses the ring memories directly
// - gather crossings around requested one, add format words, send record
// - constant record size and constant spacing between requests
// - at least three crossings of input data per request
// - statistics request returns rate counters and dead-time counter
// - route records by identifier to monitoring memory or merger
// - per channel bunch and short event check flagged by two status bits
// - bunch counter realigned by orbit reset or automatic limit
// - bad event number sets update bit in next request to realign processors
// - merger checks, formats and buffers events, channels excludable
// - buffer nearly full warning above programmable threshold
// - daq side drains buffer in auto push or push on demand
// - monitoring records unchecked into four-event per-channel memories, read by software
module trs_readout_seq
  import trs_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pins from timing receiver, channels and daq
  input  wire trs_pins_t   pins,
  // readout request bus
  output logic [15:0]      ro_word,
  output logic             ro_strobe,
  // warnings to trigger control
  output logic             request_queue_warning,
  output logic             buffer_nearly_full,
  // daq stream
  output logic [15:0]      daq_data,
  output logic             daq_valid,
  output logic             daq_last
);
  typedef struct packed {
    trs_pins_t               s1;
    trs_pins_t               s2;
    logic                    mon_ext_d;
    logic                    pull_d;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic [4:0]              ctrl;
    logic [15:0]             period;
    logic [15:0]             pcnt;
    logic [NCH-1:0]          ch_en;
    logic [QLOG:0]           qwarn;
    logic [ELOG:0]           bwarn;
    logic [2*NCH-1:0]        align;
    logic [MALOG-1:0]        mon_addr;
    logic [BCW-1:0]          bc;
    logic [EVW-1:0]          evn;
    logic                    upd;
    trs_seq_t                st;
    trs_req_t                cur;
    logic [1:0]              wi;
    logic [CW-1:0]           ci;
    logic [1:0]              ki;
    logic [NCH-1:0][5:0]     chevn;
    logic [1:0]              mslot;
    logic [NCH-1:0][15:0]    rate;
    logic [15:0]             dead;
    logic [ELOG-1:0]         wp;
    logic [ELOG-1:0]         rp;
    logic [ELOG:0]           fill;
    logic [11:0]             wcnt;
    logic [3:0]              credit;
    logic [15:0]             ro_word;
    logic                    ro_stb;
    logic                    qwarn_o;
    logic                    bfull_o;
    logic [15:0]             daq_data;
    logic                    daq_valid;
    logic                    daq_last;
  } trs_st_t;

  trs_st_t                 r;
  trs_st_t                 n;
  trs_req_t                l1_ent;
  trs_req_t                mon_ent;
  trs_req_t                l1_out;
  trs_req_t                mon_out;
  logic                    l1_valid;
  logic                    mon_valid;
  logic                    l1_pop;
  logic                    mon_pop;
  logic                    mon_req;
  logic                    mon_kind;
  logic [QLOG:0]           l1_cnt;
  logic [QLOG:0]           mon_cnt;
  logic                    ev_we;
  logic [16:0]             ev_wd;
  logic                    mon_we;
  logic [MALOG-1:0]        mon_wa;
  logic [15:0]             mon_wd;
  logic [BCW-1:0]          rd_addr;
  wire  [NCH-1:0][15:0]    rd_dat;
  wire  [NCH-1:0][BCW-1:0] rd_tag;
  logic [16:0]             evb [2**ELOG];
  logic [15:0]             monm [2**MALOG];

  trs_queue #(.W($bits(trs_req_t)), .ALOG(QLOG)) u_l1_queue (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (r.s2.l1a),
    .in_data   (l1_ent),
    .in_ready  (),
    .out_valid (l1_valid),
    .out_data  (l1_out),
    .out_ready (l1_pop),
    .count     (l1_cnt)
  );

  trs_queue #(.W($bits(trs_req_t)), .ALOG(QLOG)) u_mon_queue (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (mon_req),
    .in_data   (mon_ent),
    .in_ready  (),
    .out_valid (mon_valid),
    .out_data  (mon_out),
    .out_ready (mon_pop),
    .count     (mon_cnt)
  );

  // one ring per channel, written every crossing at the local bunch count
  for (genvar g = 0; g < NCH; g++) begin : g_ring
    logic [BCW+15:0] ring [2**BCW];
    always_ff @(posedge pclk) begin
      ring[r.bc] <= {r.s2.ch_bcn[g], r.s2.ch_data[g]};
    end
    assign {rd_tag[g], rd_dat[g]} = ring[rd_addr];
  end

  always_ff @(posedge pclk) begin
    if (ev_we) evb[r.wp] <= ev_wd;
    if (mon_we) monm[mon_wa] <= mon_wd;
  end

  always_comb begin
    logic       accept;
    logic       fwd;
    logic [1:0] stat;
    logic [15:0] word;
    logic       rd;
    accept  = 1'b0;
    fwd     = 1'b0;
    stat    = 2'b00;
    word    = 16'h0000;
    rd      = 1'b0;
    n       = r;
    ev_we   = 1'b0;
    ev_wd   = 17'h0_0000;
    mon_we  = 1'b0;
    mon_wa  = '0;
    mon_wd  = 16'h0000;
    l1_pop  = 1'b0;
    mon_pop = 1'b0;
    mon_req = 1'b0;
    mon_kind = r.ctrl[CTRL_STAT];
    // first stage feeds only the second
    n.s1 = pins;
    n.s2 = r.s1;
    n.mon_ext_d = r.s2.mon_ext;
    n.pull_d = r.s2.daq_pull;

    if (r.s2.bcr || r.bc == BC_LIMIT) n.bc = '0;
    else n.bc = r.bc + 1'b1;
    if (r.s2.l1a) n.evn = r.evn + 1'b1;
    for (int i = 0; i < NCH; i++) begin
      if (r.s2.ch_data[i] != 16'h0000) n.rate[i] = r.rate[i] + 16'h0001;
    end

    // every accepting crossing is queued while the queue has room, even back to back
    l1_ent.id  = {ID_MARK, 12'h000};
    l1_ent.evn = r.ctrl[CTRL_RED_EVN] ? r.evn : r.s2.ttc_evn;
    l1_ent.bcn = r.ctrl[CTRL_RED_BCN] ? r.bc : r.s2.ttc_bcn;

    // monitoring sources
    n.pcnt = r.pcnt + 16'h0001;
    if (r.ctrl[CTRL_PER] && r.pcnt >= r.period) begin
      n.pcnt = 16'h0000;
      mon_req = 1'b1;
    end
    if (r.s2.mon_ext && !r.mon_ext_d) mon_req = 1'b1;

    // apb: registered answer, no wait state
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel && !penable && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr)
        REG_CTRL:       n.prdata = 32'(r.ctrl);
        REG_MON_CMD:    n.prdata = 32'h0000_0000;
        REG_MON_PERIOD: n.prdata = 32'(r.period);
        REG_CH_EN:      n.prdata = 32'(r.ch_en);
        REG_QWARN:      n.prdata = 32'(r.qwarn);
        REG_BWARN:      n.prdata = 32'(r.bwarn);
        REG_STATUS:     n.prdata = 32'({r.fill, mon_cnt, l1_cnt});
        REG_ALIGN:      n.prdata = 32'(r.align);
        REG_MON_ADDR:   n.prdata = 32'(r.mon_addr);
        REG_MON_DATA:   n.prdata = 32'(monm[r.mon_addr]);
        default:        n.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && r.pready && !pwrite && paddr == REG_MON_DATA) n.mon_addr = r.mon_addr + 1'b1;
    if (psel && penable && r.pready && pwrite) begin
      case (paddr)
        REG_CTRL:       n.ctrl = pwdata[4:0];
        REG_MON_CMD: begin
          // a write of zero must not cancel a pin or periodic request
          if (pwdata[0]) begin
            mon_req = 1'b1;
            mon_kind = pwdata[1];
          end
        end
        REG_MON_PERIOD: n.period = pwdata[15:0];
        REG_CH_EN:      n.ch_en = pwdata[NCH-1:0];
        REG_QWARN:      n.qwarn = pwdata[QLOG:0];
        REG_BWARN:      n.bwarn = pwdata[ELOG:0];
        REG_ALIGN:      n.align = r.align & ~pwdata[2*NCH-1:0];
        REG_MON_ADDR:   n.mon_addr = pwdata[MALOG-1:0];
        default:        n.pslverr = 1'b0;
      endcase
    end
    mon_ent.id  = {ID_MARK, 10'h000, mon_kind, 1'b1};
    mon_ent.evn = r.evn;
    mon_ent.bcn = r.bc;

    // collector room for one whole event
    accept = (r.fill + EVT_MAX) <= EVB_SIZE;
    if (l1_valid && !accept) n.dead = r.dead + 16'h0001;
    rd_addr = (r.st == S_DATA) ? r.cur.bcn + BCW'(r.ki) - 12'h001 : r.cur.bcn;
    fwd = !r.cur.id[ID_MON] && r.ch_en[r.ci];
    stat[1] = rd_tag[r.ci] != r.cur.bcn;
    stat[0] = r.chevn[r.ci] != r.cur.evn[5:0];
    n.ro_stb = 1'b0;

    unique case (r.st)
      S_IDLE: begin
        if (accept && (l1_valid || mon_valid)) begin
          if (l1_valid) begin
            l1_pop = 1'b1;
            n.cur = l1_out;
          end else begin
            mon_pop = 1'b1;
            n.cur = mon_out;
          end
          n.cur.id[ID_UPD] = r.upd;
          n.upd = 1'b0;
          n.wi = 2'd0;
          n.st = S_BUS;
        end
      end
      S_BUS: begin
        n.ro_stb = 1'b1;
        n.ro_word = (r.wi == 2'd0) ? r.cur.id : (r.wi == 2'd1) ? r.cur.evn[15:0] : {4'h0, r.cur.bcn};
        n.wi = r.wi + 2'd1;
        if (r.wi == 2'd2) begin
          n.st = S_HDR;
          if (r.cur.id[ID_UPD]) begin
            for (int i = 0; i < NCH; i++) n.chevn[i] = r.cur.evn[5:0];
          end
        end
      end
      S_HDR: begin
        ev_we = !r.cur.id[ID_MON];
        ev_wd = {1'b0, FMT_EVH, r.cur.bcn};
        n.wcnt = 12'h001;
        n.ci = '0;
        n.st = S_CH;
      end
      S_CH: begin
        word = {FMT_CH, 4'(r.ci), stat, r.chevn[r.ci]};
        if (r.cur.id[ID_MON]) begin
          mon_we = 1'b1;
          mon_wa = {r.ci, r.mslot, 2'd0};
          mon_wd = {FMT_CH, 4'(r.ci), 2'b00, r.chevn[r.ci]};
        end else if (fwd) begin
          ev_we = 1'b1;
          ev_wd = {1'b0, word};
          n.wcnt = r.wcnt + 12'h001;
          n.align[2*r.ci +: 2] = n.align[2*r.ci +: 2] | stat;
          if (stat[0]) n.upd = 1'b1;
        end
        n.ki = 2'd0;
        n.st = S_DATA;
      end
      S_DATA: begin
        if (r.cur.id[ID_STAT]) begin
          // statistics replace ring data, record size unchanged
          word = (r.ki == 2'd0) ? r.rate[r.ci] : (r.ki == 2'd1) ? r.dead : 16'h0000;
        end else begin
          word = rd_dat[r.ci];
        end
        if (r.cur.id[ID_MON]) begin
          mon_we = 1'b1;
          mon_wa = {r.ci, r.mslot, 2'(r.ki + 2'd1)};
          mon_wd = word;
        end else if (fwd) begin
          ev_we = 1'b1;
          ev_wd = {1'b0, word};
          n.wcnt = r.wcnt + 12'h001;
        end
        n.ki = r.ki + 2'd1;
        if (r.ki == 2'(HIST - 1)) begin
          n.ci = r.ci + 1'b1;
          n.st = (r.ci == CW'(NCH - 1)) ? S_TRL : S_CH;
        end
      end
      S_TRL: begin
        if (r.cur.id[ID_MON]) begin
          n.mslot = r.mslot + 2'd1;
        end else begin
          ev_we = 1'b1;
          ev_wd = {1'b1, FMT_TRL, r.wcnt + 12'h001};
          for (int i = 0; i < NCH; i++) n.chevn[i] = r.chevn[i] + 6'h01;
        end
        n.st = S_IDLE;
      end
    endcase
    if (ev_we) n.wp = r.wp + 1'b1;

    // daq side; ready arrives through the pin synchroniser
    if (r.daq_valid && r.s2.daq_ready) n.daq_valid = 1'b0;
    if ((!r.daq_valid || r.s2.daq_ready) && r.fill != '0 && (r.ctrl[CTRL_AUTO] || r.credit != 4'h0)) begin
      rd = 1'b1;
      n.daq_valid = 1'b1;
      n.daq_data = evb[r.rp][15:0];
      n.daq_last = evb[r.rp][16];
      n.rp = r.rp + 1'b1;
    end
    // credits saturate at fifteen instead of wrapping to zero
    n.credit = r.credit + 4'(r.s2.daq_pull && !r.pull_d && r.credit != 4'hf)
             - 4'(rd && evb[r.rp][16] && !r.ctrl[CTRL_AUTO]);
    n.fill = r.fill + (ELOG+1)'(ev_we) - (ELOG+1)'(rd);
    n.qwarn_o = l1_cnt >= r.qwarn;
    n.bfull_o = r.fill > r.bwarn;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.st     <= S_IDLE;
      r.ctrl   <= CTRL_RST;
      r.period <= PERIOD_RST;
      r.ch_en  <= CHEN_RST;
      r.qwarn  <= QWARN_RST;
      r.bwarn  <= BWARN_RST;
    end else begin
      r <= n;
    end
  end

  assign prdata                = r.prdata;
  assign pready                = r.pready;
  assign pslverr               = r.pslverr;
  assign ro_word               = r.ro_word;
  assign ro_strobe             = r.ro_stb;
  assign request_queue_warning = r.qwarn_o;
  assign buffer_nearly_full    = r.bfull_o;
  assign daq_data              = r.daq_data;
  assign daq_valid             = r.daq_valid;
  assign daq_last              = r.daq_last;
endmodule : trs_readout_seq
